// *** logic/rtca_top.sv ***
/*
 * rtca_top: day and weekday alarm compare with sticky alarm flag, and the
 * 8-bit countdown timer with four source clocks and level or pulse irq.
 * Assumes a byte register port driven by the serial front end on mclk,
 * the calendar, its 1 Hz tick (offset correction already applied) and the
 * second/minute/hour field matches supplied on mclk; osc_32k is a pin.
 */
//
// Contract
// - day alarm: disable bit7, BCD day 5:0
// - weekday alarm: disable bit7, weekday 2:0
// - disabled alarm fields never take part
// - flag set when enabled fields first match
// - alarm irq enabled: output follows alarm flag
// - alarm flag stays until cleared; new match sets it again
// - count at 10h, control at 11h, count resets 0
// - bits 4:3 select source, reset 11
// - bit2 runs, bit1 irq enable, 7:5 zero
// - bit0 selects level or pulse irq
// - each source tick decrements the count
// - zero count halts timer; host loads 1..255
// - 1 Hz sources follow corrected second tick
// - expiry from 1 sets flag and reloads
// - only host clear resets expired flag
// - count read returns live remaining value
module rtca_top
(
   input  wire logic       mclk,
   input  wire logic       rst_n,
   input  wire logic [7:0] reg_addr,
   input  wire logic [7:0] reg_wdata,
   input  wire logic       reg_wr,
   input  wire logic       reg_rd,
   output logic      [7:0] reg_rdata,
   input  wire logic       osc_32k,
   input  wire logic       sec_tick,
   input  wire logic [5:0] cur_day,
   input  wire logic [2:0] cur_weekday,
   input  wire logic       sec_match_ok,
   input  wire logic       min_match_ok,
   input  wire logic       hour_match_ok,
   input  wire logic       alarm_irq_enable,
   input  wire logic       alarm_flag_clear,
   input  wire logic       countdown_flag_clear,
   output logic            alarm_hit_flag,
   output logic            countdown_expired_flag,
   output logic            int_n
);
   logic [7:0] day_of_month_alarm, next_day_of_month_alarm;
   logic [7:0] day_of_week_alarm,  next_day_of_week_alarm;
   logic [7:0] countdown_count,    next_countdown_count;
   logic [7:0] countdown_reload,   next_countdown_reload;
   logic [7:0] countdown_control,  next_countdown_control;
   logic [7:0] next_reg_rdata;
   logic       next_alarm_hit_flag, next_countdown_expired_flag, next_int_n;
   logic       osc_meta, osc_sync, osc_prev;
   logic [8:0] osc_div, next_osc_div;
   logic [5:0] sec_div, next_sec_div;
   logic [9:0] pulse_cnt, next_pulse_cnt;
   logic       match_prev;
   logic       osc_edge, src_tick, alarm_match, expire;
   rtca_pkg::rtca_src_t countdown_clock_select;
   logic       countdown_run, countdown_irq_enable, countdown_irq_pulse_mode;
   logic       day_match_disable, weekday_match_disable;

   // bcd-safe field compare, used for both alarm fields
   function automatic logic field_ok(input logic dis, input logic [5:0] a,
                                     input logic [5:0] b);
      field_ok = dis | (a == b);
   endfunction

   // oscillator pin synchroniser; only osc_sync and osc_prev feed logic
   always_ff @(posedge mclk)
   begin
      osc_meta   <= osc_32k;
      osc_sync   <= osc_meta;
      osc_prev   <= osc_sync;
      match_prev <= rst_n ? alarm_match : 1'b1;
   end

   // field decode
   assign day_match_disable        = day_of_month_alarm[rtca_pkg::POS_MATCH_DIS];
   assign weekday_match_disable    = day_of_week_alarm[rtca_pkg::POS_MATCH_DIS];
   assign countdown_clock_select   =
      rtca_pkg::rtca_src_t'(countdown_control[rtca_pkg::POS_CLK_SEL +: 2]);
   assign countdown_run            = countdown_control[rtca_pkg::POS_RUN];
   assign countdown_irq_enable     = countdown_control[rtca_pkg::POS_IRQ_EN];
   assign countdown_irq_pulse_mode = countdown_control[rtca_pkg::POS_PULSE_MODE];
   assign osc_edge                 = osc_sync & ~osc_prev;

   // disabled fields pass; match_prev starts high so reset cannot fire it
   assign alarm_match = sec_match_ok & min_match_ok & hour_match_ok
      & field_ok(day_match_disable, day_of_month_alarm[5:0], cur_day)
      & field_ok(weekday_match_disable, {3'h0, day_of_week_alarm[2:0]},
                 {3'h0, cur_weekday});

   // source tick select; slow sources ride the corrected second tick
   always_comb
   begin
      case (countdown_clock_select)
         rtca_pkg::RTCA_SRC_4096: src_tick = osc_edge & (osc_div[2:0] == 3'h7);
         rtca_pkg::RTCA_SRC_64:   src_tick = osc_edge & (osc_div == 9'h1FF);
         rtca_pkg::RTCA_SRC_1HZ:  src_tick = sec_tick;
         default:                 src_tick = sec_tick &
            (sec_div == 6'(rtca_pkg::SEC_PER_MIN - 1));
      endcase
   end

   // a zero count never expires and never moves
   assign expire = countdown_run & src_tick & (countdown_count == 8'h01);

   // next-state for registers, counters, flags and outputs
   always_comb
   begin
      next_day_of_month_alarm = day_of_month_alarm;
      next_day_of_week_alarm  = day_of_week_alarm;
      next_countdown_control  = countdown_control;
      next_countdown_reload   = countdown_reload;
      next_countdown_count    = countdown_count;
      next_osc_div            = osc_edge ? osc_div + 9'h001 : osc_div;
      next_sec_div            = sec_div;
      next_pulse_cnt          = pulse_cnt;
      next_reg_rdata          = reg_rdata;
      if (sec_tick)
      begin
         next_sec_div = (sec_div == 6'(rtca_pkg::SEC_PER_MIN - 1)) ? 6'h00
                        : sec_div + 6'h01;
      end
      // countdown: decrement, reload on expiry, hold at zero
      if (countdown_run && src_tick && countdown_count != 8'h00)
      begin
         next_countdown_count = expire ? countdown_reload
                                : countdown_count - 8'h01;
      end
      // pulse lasts one 4096 Hz period or 1/64 s, counted in osc edges
      if (expire)
      begin
         next_pulse_cnt = (countdown_clock_select == rtca_pkg::RTCA_SRC_4096)
                          ? 10'(rtca_pkg::OSC_PER_4096)
                          : 10'(rtca_pkg::OSC_PER_64);
      end
      else if (osc_edge && pulse_cnt != 10'h000)
      begin
         next_pulse_cnt = pulse_cnt - 10'h001;
      end
      // register writes; a count write takes immediate effect
      if (reg_wr)
      begin
         if (reg_addr == rtca_pkg::OFS_MDAY_ALARM)
         begin
            next_day_of_month_alarm = reg_wdata & rtca_pkg::MASK_DAY;
         end
         else if (reg_addr == rtca_pkg::OFS_WDAY_ALARM)
         begin
            next_day_of_week_alarm = reg_wdata & rtca_pkg::MASK_WDAY;
         end
         else if (reg_addr == rtca_pkg::OFS_CD_COUNT)
         begin
            next_countdown_reload = reg_wdata;
            next_countdown_count  = reg_wdata;
         end
         else if (reg_addr == rtca_pkg::OFS_CD_CTRL)
         begin
            next_countdown_control = reg_wdata & rtca_pkg::MASK_CTRL;
         end
      end
      // register reads, unmapped offsets answer zero
      if (reg_rd)
      begin
         if (reg_addr == rtca_pkg::OFS_MDAY_ALARM)
            next_reg_rdata = day_of_month_alarm;
         else if (reg_addr == rtca_pkg::OFS_WDAY_ALARM)
            next_reg_rdata = day_of_week_alarm;
         else if (reg_addr == rtca_pkg::OFS_CD_COUNT)
            next_reg_rdata = countdown_count;
         else if (reg_addr == rtca_pkg::OFS_CD_CTRL)
            next_reg_rdata = countdown_control;
         else
            next_reg_rdata = 8'h00;
      end
      // sticky flags: a set in the clear cycle wins
      next_alarm_hit_flag = (alarm_hit_flag & ~alarm_flag_clear)
                            | (alarm_match & ~match_prev);
      next_countdown_expired_flag = (countdown_expired_flag
                                     & ~countdown_flag_clear) | expire;
      // pulse mode asserts with the flag, so use expire as well
      next_int_n = ~((alarm_irq_enable & next_alarm_hit_flag)
                     | (countdown_irq_enable &
                        (countdown_irq_pulse_mode
                         ? (expire | pulse_cnt != 10'h000)
                         : next_countdown_expired_flag)));
   end

   // state registers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         day_of_month_alarm     <= rtca_pkg::RST_DAY;
         day_of_week_alarm      <= rtca_pkg::RST_WDAY;
         countdown_count        <= rtca_pkg::RST_COUNT;
         countdown_reload       <= rtca_pkg::RST_COUNT;
         countdown_control      <= rtca_pkg::RST_CTRL;
         osc_div                <= 9'h000;
         sec_div                <= 6'h00;
         pulse_cnt              <= 10'h000;
         reg_rdata              <= 8'h00;
         alarm_hit_flag         <= 1'b0;
         countdown_expired_flag <= 1'b0;
         int_n                  <= 1'b1;
      end
      else
      begin
         day_of_month_alarm     <= next_day_of_month_alarm;
         day_of_week_alarm      <= next_day_of_week_alarm;
         countdown_count        <= next_countdown_count;
         countdown_reload       <= next_countdown_reload;
         countdown_control      <= next_countdown_control;
         osc_div                <= next_osc_div;
         sec_div                <= next_sec_div;
         pulse_cnt              <= next_pulse_cnt;
         reg_rdata              <= next_reg_rdata;
         alarm_hit_flag         <= next_alarm_hit_flag;
         countdown_expired_flag <= next_countdown_expired_flag;
         int_n                  <= next_int_n;
      end
   end

   // checks
   sequence s_expire;
      countdown_run && src_tick && countdown_count == 8'h01 && !reg_wr;
   endsequence
   sequence s_new_match;
      alarm_match && !match_prev;
   endsequence

   a_unused_bits_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      day_of_month_alarm[6] == 1'b0 && day_of_week_alarm[6:3] == 4'h0)
      else $error("unused alarm bits set");
   a_ctrl_upper_zero: assert property (@(posedge mclk) disable iff (!rst_n)
      countdown_control[7:5] == 3'h0)
      else $error("unused control bits set");
   a_alarm_sets_flag: assert property (@(posedge mclk) disable iff (!rst_n)
      s_new_match |=> alarm_hit_flag)
      else $error("alarm match did not set flag");
   a_alarm_flag_holds: assert property (@(posedge mclk) disable iff (!rst_n)
      alarm_hit_flag && !alarm_flag_clear |=> alarm_hit_flag)
      else $error("alarm flag dropped without clear");
   a_alarm_irq_level: assert property (@(posedge mclk) disable iff (!rst_n)
      alarm_irq_enable && $rose(alarm_hit_flag) |-> !int_n)
      else $error("irq did not follow alarm flag");
   a_expire_reload: assert property (@(posedge mclk) disable iff (!rst_n)
      s_expire |=> countdown_expired_flag && countdown_count == $past(countdown_reload))
      else $error("expiry did not set flag and reload");
   a_zero_halts: assert property (@(posedge mclk) disable iff (!rst_n)
      countdown_count == 8'h00 && !reg_wr |=> countdown_count == 8'h00)
      else $error("zero count moved");
   a_tick_decrements: assert property (@(posedge mclk) disable iff (!rst_n)
      countdown_run && src_tick && countdown_count > 8'h01 && !reg_wr
      |=> countdown_count == $past(countdown_count) - 8'h01)
      else $error("count did not decrement");
   a_timer_flag_sticky: assert property (@(posedge mclk) disable iff (!rst_n)
      countdown_expired_flag && !countdown_flag_clear |=> countdown_expired_flag)
      else $error("timer flag cleared by counting");
   a_live_count_read: assert property (@(posedge mclk) disable iff (!rst_n)
      reg_rd && reg_addr == rtca_pkg::OFS_CD_COUNT |=> reg_rdata == $past(countdown_count))
      else $error("count read not live");
   a_pulse_irq: assert property (@(posedge mclk) disable iff (!rst_n)
      ((countdown_irq_enable && countdown_irq_pulse_mode) and s_expire) |=> !int_n)
      else $error("pulse irq missing");
endmodule

// *** logic/rtca_pkg.sv ***
/*
 * rtca_pkg: register offsets, field positions, reset values and timing
 * counts for the alarm compare and countdown timer section.
 * Assumes a 10 MHz mclk and a 32.768 kHz oscillator pin.
 */
package rtca_pkg;
   // register offsets on the byte register port
   localparam logic [7:0] OFS_MDAY_ALARM = 8'h0E;
   localparam logic [7:0] OFS_WDAY_ALARM = 8'h0F;
   localparam logic [7:0] OFS_CD_COUNT   = 8'h10;
   localparam logic [7:0] OFS_CD_CTRL    = 8'h11;
   // field positions
   localparam int         POS_MATCH_DIS  = 7;
   localparam int         POS_CLK_SEL    = 3;
   localparam int         POS_RUN        = 2;
   localparam int         POS_IRQ_EN     = 1;
   localparam int         POS_PULSE_MODE = 0;
   // readable bits of each register, others read zero
   localparam logic [7:0] MASK_DAY       = 8'hBF;
   localparam logic [7:0] MASK_WDAY      = 8'h87;
   localparam logic [7:0] MASK_CTRL      = 8'h1F;
   // reset values
   localparam logic [7:0] RST_DAY        = 8'h80;
   localparam logic [7:0] RST_WDAY       = 8'h80;
   localparam logic [7:0] RST_COUNT      = 8'h00;
   localparam logic [7:0] RST_CTRL       = 8'h18;
   // source clock select codes
   typedef enum logic [1:0]
   {
      RTCA_SRC_4096 = 2'b00,
      RTCA_SRC_64   = 2'b01,
      RTCA_SRC_1HZ  = 2'b10,
      RTCA_SRC_1_60 = 2'b11
   } rtca_src_t;
   // oscillator edges per source tick, seconds per 1/60 Hz tick
   localparam int         OSC_PER_4096   = 8;
   localparam int         OSC_PER_64     = 512;
   localparam int         SEC_PER_MIN    = 60;
endpackage

// *** sim/rtca_host_model.sv ***
/*
 * rtca_host_model: host side of the byte register port, one strobe per byte.
 * Assumes its tasks are called at mclk low and that mclk is free running.
 */
module rtca_host_model
(
   input  wire logic       mclk,
   output logic      [7:0] reg_addr,
   output logic      [7:0] reg_wdata,
   output logic            reg_wr,
   output logic            reg_rd,
   input  wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ns;

   // idle port at time zero
   initial
   begin
      reg_addr  = 8'h00;
      reg_wdata = 8'h00;
      reg_wr    = 1'b0;
      reg_rd    = 1'b0;
   end

   // released lines show the inverse, so stale values never look valid
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      reg_addr  = a;
      reg_wdata = d;
      reg_wr    = 1'b1;
      @(negedge mclk);
      reg_wr    = 1'b0;
      reg_addr  = ~a;
      reg_wdata = ~d;
      @(negedge mclk);
   endtask

   // read data is registered, so it is taken one edge after the strobe
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      reg_addr = a;
      reg_rd   = 1'b1;
      @(negedge mclk);
      reg_rd   = 1'b0;
      reg_addr = ~a;
      @(negedge mclk);
      d        = reg_rdata;
   endtask
endmodule

// *** sim/test_rtca_top.sv ***
/*
 * test_rtca_top: self-checking bench for alarm compare and countdown timer.
 * Assumes the host model drives the register port; inputs change at mclk low.
 */
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin error_cnt++; \
   $display("unexpected %s: expected %h seen %h", n, e, g); end end
module test_rtca_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic       mclk = 0, rst_n = 0, osc_32k = 0, sec_tick = 0;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, got, v, a;
   logic       reg_wr, reg_rd, alarm_hit_flag, countdown_expired_flag, int_n;
   logic [5:0] cur_day = 0;
   logic [2:0] cur_weekday = 0;
   logic       alarm_irq_enable = 1, alarm_flag_clear = 0, countdown_flag_clear = 0;
   int         error_cnt = 0, checks_done = 0, seed = 59, i;

   // 10 MHz system clock; crystal runs unrelated in phase
   always #50 mclk = ~mclk;
   always #15259 osc_32k = ~osc_32k;

   rtca_host_model host (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
   rtca_top dut (.mclk(mclk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .osc_32k(osc_32k),
      .sec_tick(sec_tick), .cur_day(cur_day), .cur_weekday(cur_weekday),
      .sec_match_ok(1'b1), .min_match_ok(1'b1), .hour_match_ok(1'b1),
      .alarm_irq_enable(alarm_irq_enable), .alarm_flag_clear(alarm_flag_clear),
      .countdown_flag_clear(countdown_flag_clear), .alarm_hit_flag(alarm_hit_flag),
      .countdown_expired_flag(countdown_expired_flag), .int_n(int_n));

   // readback expected from the access masks; unmapped reads zero
   function automatic logic [7:0] exp_rd(input logic [7:0] ad, input logic [7:0] d);
      case (ad)
         rtca_pkg::OFS_MDAY_ALARM: return d & rtca_pkg::MASK_DAY;
         rtca_pkg::OFS_WDAY_ALARM: return d & rtca_pkg::MASK_WDAY;
         rtca_pkg::OFS_CD_COUNT:   return d;
         rtca_pkg::OFS_CD_CTRL:    return d & rtca_pkg::MASK_CTRL;
         default:                  return 8'h00;
      endcase
   endfunction

   task automatic end_sim;
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic wait_n(input int n);
      repeat (n) @(negedge mclk);
   endtask

   task automatic tick(input int n);
      repeat (n)
      begin
         sec_tick = 1'b1;
         @(negedge mclk);
         sec_tick = 1'b0;
         @(negedge mclk);
      end
   endtask

   task automatic pulse_clr(input logic al, input logic cd);
      alarm_flag_clear     = al;
      countdown_flag_clear = cd;
      @(negedge mclk);
      alarm_flag_clear     = 1'b0;
      countdown_flag_clear = 1'b0;
   endtask

   task automatic chk_reg(input logic [7:0] ad, input logic [7:0] e);
      host.rd(ad, got);
      `CHK("reg_rdata", e, got)
   endtask

   // match starts false, then the calendar steps onto the given day/weekday
   task automatic alarm_case(input logic [7:0] dreg, input logic [7:0] wreg,
                             input logic [5:0] d, input logic [2:0] w, input logic e);
      cur_day     = 6'h00;
      cur_weekday = 3'h0;
      pulse_clr(1'b1, 1'b0);
      host.wr(8'h0E, dreg);
      host.wr(8'h0F, wreg);
      cur_day     = d;
      cur_weekday = w;
      wait_n(2);
      `CHK("alarm_hit_flag", e, alarm_hit_flag)
      `CHK("int_n", ~e, int_n)
   endtask

   // watchdog sized well above the 4 kHz timer wait
   initial
   begin
      #5_000_000;
      error_cnt++;
      end_sim();
   end

   initial
   begin
      wait_n(10);
      rst_n = 1'b1;
      chk_reg(8'h0E, 8'h80);
      chk_reg(8'h0F, 8'h80);
      chk_reg(8'h10, 8'h00);
      chk_reg(8'h11, 8'h18);
      // random bytes over all offsets, 12h unmapped; timer kept stopped
      for (i = 0; i < 15; i++)
      begin
         v = 8'($random(seed));
         a = 8'h0E + 8'(i % 5);
         if (a == 8'h11) v[2] = 1'b0;
         if (a == 8'h11) v[4:3] = 2'b11;
         if (a == 8'h10 && v == 8'h00) v = 8'h01;
         host.wr(a, v);
         chk_reg(a, exp_rd(a, v));
      end
      alarm_case(8'h15, 8'h80, 6'h15, 3'h3, 1'b1);
      alarm_case(8'h15, 8'h04, 6'h15, 3'h3, 1'b0);
      alarm_case(8'h80, 8'h04, 6'h00, 3'h4, 1'b1);
      // clear during a lasting match must hold until the next new match
      pulse_clr(1'b1, 1'b0);
      wait_n(2);
      `CHK("alarm_hit_flag", 1'b0, alarm_hit_flag)
      cur_weekday = 3'h5;
      wait_n(2);
      cur_weekday = 3'h4;
      wait_n(2);
      `CHK("alarm_hit_flag", 1'b1, alarm_hit_flag)
      alarm_irq_enable = 1'b0;
      wait_n(2);
      `CHK("int_n", 1'b1, int_n)
      cur_weekday = 3'h0;
      pulse_clr(1'b1, 1'b0);
      // 1 Hz source, level irq
      host.wr(8'h10, 8'h03);
      host.wr(8'h11, 8'h16);
      tick(1);
      chk_reg(8'h10, 8'h02);
      tick(1);
      chk_reg(8'h10, 8'h01);
      tick(1);
      `CHK("countdown_expired_flag", 1'b1, countdown_expired_flag)
      `CHK("int_n", 1'b0, int_n)
      chk_reg(8'h10, 8'h03);
      tick(1);
      `CHK("countdown_expired_flag", 1'b1, countdown_expired_flag)
      pulse_clr(1'b0, 1'b1);
      `CHK("int_n", 1'b1, int_n)
      host.wr(8'h11, 8'h12);
      tick(2);
      chk_reg(8'h10, 8'h02);
      // zero count halts even with run set
      host.wr(8'h10, 8'h00);
      host.wr(8'h11, 8'h16);
      tick(2);
      chk_reg(8'h10, 8'h00);
      `CHK("countdown_expired_flag", 1'b0, countdown_expired_flag)
      // 1/60 source: exactly one step per 60 seconds
      host.wr(8'h10, 8'h02);
      host.wr(8'h11, 8'h1E);
      tick(60);
      chk_reg(8'h10, 8'h01);
      tick(60);
      `CHK("countdown_expired_flag", 1'b1, countdown_expired_flag)
      pulse_clr(1'b0, 1'b1);
      // 4.096 kHz source, pulse irq
      host.wr(8'h10, 8'h02);
      host.wr(8'h11, 8'h07);
      i = 0;
      while (countdown_expired_flag !== 1'b1 && i < 10000)
      begin
         @(negedge mclk);
         i++;
      end
      `CHK("countdown_expired_flag", 1'b1, countdown_expired_flag)
      `CHK("int_n", 1'b0, int_n)
      wait_n(3000);
      `CHK("int_n", 1'b1, int_n)
      `CHK("countdown_expired_flag", 1'b1, countdown_expired_flag)
      host.wr(8'h11, 8'h18);
      pulse_clr(1'b0, 1'b1);
      end_sim();
   end
endmodule
